// ===== rdm_cfg.svh
// Function
// - each of three test pins has its own six-bit signal selector
// - selector registers at 0xDF2F, 0xDF30, 0xDF31 drive pins 1.7, 1.6, 1.5
// - selector code zero leaves the pin with the ordinary port registers
// - a listed nonzero code overrides function select and makes the pin an output; other codes such as 011110 leave the port registers
// - code 001000 outputs preamble quality reached
// - code 001001 outputs clear channel, criterion set by the radio's mode
// - code 001110 outputs carrier sense
// - code 001111 outputs crc match flag, cleared on receive entry or restart
// - codes 010110 and 010111 output hard receive bits one and zero
// - code 011101 outputs the receive symbol tick
// - code 011011 outputs the power amplifier powerdown control
// - code 011100 outputs the low noise amplifier powerdown control
// - code 101111 outputs constant zero, or one with the invert flag set
`ifndef RDM_CFG_SVH
`define RDM_CFG_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define RDM_ADDR_CFG_HI 16'hDF2F
`define RDM_ADDR_CFG_MID 16'hDF30
`define RDM_ADDR_CFG_LO 16'hDF31
`define RDM_ADDR_STATUS 16'hDF32

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define RDM_SEL_LSB 0
`define RDM_SEL_MSB 5
`define RDM_INV_BIT 6
`define RDM_CFG_MASK 8'h7F
`define RDM_CFG_RST 8'h00
`define RDM_RDATA_IDLE 8'h00
`define RDM_STS_OVR_LSB 0
`define RDM_STS_PIN_LSB 3
`define RDM_STS_CRC_BIT 6

// ----------------------------------------
// selector codes
// ----------------------------------------
`define RDM_CODE_PORT 6'h00
`define RDM_CODE_PREAMBLE 6'h08
`define RDM_CODE_CCA 6'h09
`define RDM_CODE_CS 6'h0E
`define RDM_CODE_CRC 6'h0F
`define RDM_CODE_HARD1 6'h16
`define RDM_CODE_HARD0 6'h17
`define RDM_CODE_PAPD 6'h1B
`define RDM_CODE_LNAPD 6'h1C
`define RDM_CODE_TICK 6'h1D
`define RDM_CODE_ZERO 6'h2F
`define RDM_CODE_RSVD 6'h1E

`endif

// ===== rdm_pkg.sv
package rdm_pkg;

  // ----------------------------------------
  // radio status levels
  // ----------------------------------------
  typedef struct packed {
    logic preamble_reached;
    logic clear_channel;
    logic carrier_sense;
    logic [1:0] receive_hard_bits;
    logic symbol_tick;
    logic power_amp_powerdown;
    logic low_noise_amp_powerdown;
  } rdm_radio_status_t;

  // ----------------------------------------
  // ordinary port control of one pin
  // ----------------------------------------
  typedef struct packed {
    logic gpio_out;
    logic gpio_dir;
    logic function_select;
    logic periph_out;
    logic periph_oe;
  } rdm_port_pin_t;

  // ----------------------------------------
  // resolved drive of one pin
  // ----------------------------------------
  typedef struct packed {
    logic value;
    logic oe_n;
    logic override;
  } rdm_pin_drive_t;

endpackage : rdm_pkg

// ===== rdm_crc_flag.sv
`timescale 1ns/1ns
module rdm_crc_flag (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // radio events
  input wire logic check_i,
  input wire logic match_i,
  input wire logic rx_start_i,
  // flag
  output logic flag_o
);

  logic next_flag;

  // set by a matching compare, cleared by a miss or receive entry
  always_comb begin
    next_flag = flag_o;
    if (check_i && match_i) begin
      next_flag = 1'b1;
    end else if (rx_start_i || check_i) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= next_flag;
    end
  end

endmodule : rdm_crc_flag

// ===== rdm_pin_sel.sv
`timescale 1ns/1ns
`include "rdm_cfg.svh"
module rdm_pin_sel (
  // configuration
  input wire logic [7:0] cfg_i,
  // sources
  input wire rdm_pkg::rdm_radio_status_t status_i,
  input wire logic crc_ok_i,
  input wire rdm_pkg::rdm_port_pin_t port_i,
  // result
  output rdm_pkg::rdm_pin_drive_t drive_o
);

  always_comb begin
    logic sig;
    logic hit;
    sig = 1'b0;
    hit = 1'b1;
    case (cfg_i[`RDM_SEL_MSB:`RDM_SEL_LSB])
      `RDM_CODE_PREAMBLE: sig = status_i.preamble_reached;
      `RDM_CODE_CCA: sig = status_i.clear_channel;
      `RDM_CODE_CS: sig = status_i.carrier_sense;
      `RDM_CODE_CRC: sig = crc_ok_i;
      `RDM_CODE_HARD1: sig = status_i.receive_hard_bits[1];
      `RDM_CODE_HARD0: sig = status_i.receive_hard_bits[0];
      `RDM_CODE_PAPD: sig = status_i.power_amp_powerdown;
      `RDM_CODE_LNAPD: sig = status_i.low_noise_amp_powerdown;
      `RDM_CODE_TICK: sig = status_i.symbol_tick;
      `RDM_CODE_ZERO: sig = 1'b0;
      default: hit = 1'b0;
    endcase
    if (hit) begin
      drive_o = '{value: sig ^ cfg_i[`RDM_INV_BIT], oe_n: 1'b0,
                  override: 1'b1};
    end else if (port_i.function_select) begin
      drive_o = '{value: port_i.periph_out, oe_n: !port_i.periph_oe,
                  override: 1'b0};
    end else begin
      drive_o = '{value: port_i.gpio_out, oe_n: !port_i.gpio_dir,
                  override: 1'b0};
    end
  end

endmodule : rdm_pin_sel

// ===== rdm_top.sv
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "rdm_cfg.svh"
module rdm_top #(
  parameter int NUM_PINS = 3
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // radio status
  input wire rdm_pkg::rdm_radio_status_t status_i,
  input wire logic crc_check_i,
  input wire logic crc_match_i,
  input wire logic rx_start_i,
  // ordinary port control, index 0 is pin 1.5
  input wire rdm_pkg::rdm_port_pin_t [2:0] port_i,
  // pins, index 0 is pin 1.5
  output logic [2:0] pin_o,
  output logic [2:0] pin_oe_n_o
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (NUM_PINS != 3) begin : g_bad_pins
    $error("rdm_top serves exactly three pins");
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] cfg [3];
  logic [7:0] next_cfg [3];
  logic [7:0] next_rdata;
  logic crc_ok;
  rdm_pkg::rdm_pin_drive_t drive [3];
  logic [2:0] ovr;
  logic [2:0] next_ovr;
  logic [2:0] next_pin;
  logic [2:0] next_oe_n;

  // pin 2 is 1.7, pin 1 is 1.6, pin 0 is 1.5
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_cfg[i] = cfg[i];
    end
    if (wr_i) begin
      case (addr_i)
        `RDM_ADDR_CFG_HI: next_cfg[2] = wdata_i & `RDM_CFG_MASK;
        `RDM_ADDR_CFG_MID: next_cfg[1] = wdata_i & `RDM_CFG_MASK;
        `RDM_ADDR_CFG_LO: next_cfg[0] = wdata_i & `RDM_CFG_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < 3; i++) begin
        cfg[i] <= `RDM_CFG_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        cfg[i] <= next_cfg[i];
      end
    end
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  always_comb begin
    next_rdata = `RDM_RDATA_IDLE;
    if (rd_i) begin
      case (addr_i)
        `RDM_ADDR_CFG_HI: next_rdata = cfg[2];
        `RDM_ADDR_CFG_MID: next_rdata = cfg[1];
        `RDM_ADDR_CFG_LO: next_rdata = cfg[0];
        `RDM_ADDR_STATUS: begin
          next_rdata[`RDM_STS_OVR_LSB +: 3] = ovr;
          next_rdata[`RDM_STS_PIN_LSB +: 3] = pin_o;
          next_rdata[`RDM_STS_CRC_BIT] = crc_ok;
        end
        default: next_rdata = `RDM_RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= `RDM_RDATA_IDLE;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------
  // crc match flag
  // ----------------------------------------
  rdm_crc_flag u_crc_flag (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .check_i(crc_check_i),
    .match_i(crc_match_i),
    .rx_start_i(rx_start_i),
    .flag_o(crc_ok)
  );

  // ----------------------------------------
  // per-pin selection
  // ----------------------------------------
  for (genvar g = 0; g < 3; g++) begin : g_pin
    rdm_pin_sel u_sel (
      .cfg_i(cfg[g]),
      .status_i(status_i),
      .crc_ok_i(crc_ok),
      .port_i(port_i[g]),
      .drive_o(drive[g])
    );
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_pin[i] = drive[i].value;
      next_oe_n[i] = drive[i].oe_n;
      next_ovr[i] = drive[i].override;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_o <= 3'h0;
      pin_oe_n_o <= 3'h7;
      ovr <= 3'h0;
    end else begin
      pin_o <= next_pin;
      pin_oe_n_o <= next_oe_n;
      ovr <= next_ovr;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  logic [5:0] sel0;
  logic [5:0] sel1;
  logic [5:0] sel2;
  logic inv0;
  logic inv1;
  logic inv2;
  assign sel0 = cfg[0][`RDM_SEL_MSB:`RDM_SEL_LSB];
  assign sel1 = cfg[1][`RDM_SEL_MSB:`RDM_SEL_LSB];
  assign sel2 = cfg[2][`RDM_SEL_MSB:`RDM_SEL_LSB];
  assign inv0 = cfg[0][`RDM_INV_BIT];
  assign inv1 = cfg[1][`RDM_INV_BIT];
  assign inv2 = cfg[2][`RDM_INV_BIT];

  sequence hi_write_s;
    wr_i && addr_i == `RDM_ADDR_CFG_HI;
  endsequence

  write_then_read_a: assert property (
    hi_write_s ##1 (rd_i && addr_i == `RDM_ADDR_CFG_HI && !wr_i)
    |=> rdata_o == ($past(wdata_i, 2) & `RDM_CFG_MASK))
    else $error("selector for pin 1.7 did not read back");

  read_idle_a: assert property (
    !rd_i |=> rdata_o == `RDM_RDATA_IDLE)
    else $error("read data not idle outside an answer");

  port_mode_a: assert property (
    sel0 == `RDM_CODE_PORT && !port_i[0].function_select
    |=> pin_o[0] == $past(port_i[0].gpio_out)
        && pin_oe_n_o[0] == !$past(port_i[0].gpio_dir))
    else $error("pin 1.5 did not follow port registers");

  override_out_a: assert property (
    (sel2 == `RDM_CODE_PREAMBLE || sel2 == `RDM_CODE_TICK)
    && port_i[2].function_select |=> !pin_oe_n_o[2] && ovr[2])
    else $error("selected pin 1.7 not forced to output");

  preamble_route_a: assert property (
    sel1 == `RDM_CODE_PREAMBLE
    |=> pin_o[1] == ($past(status_i.preamble_reached) ^ $past(inv1)))
    else $error("preamble quality not on pin 1.6");

  cca_route_a: assert property (
    sel0 == `RDM_CODE_CCA
    |=> pin_o[0] == ($past(status_i.clear_channel) ^ $past(inv0)))
    else $error("clear channel not on pin 1.5");

  cs_route_a: assert property (
    sel2 == `RDM_CODE_CS && !inv2
    |=> pin_o[2] == $past(status_i.carrier_sense))
    else $error("carrier sense not on pin 1.7");

  crc_clear_a: assert property (
    rx_start_i && !(crc_check_i && crc_match_i) && sel1 == `RDM_CODE_CRC
    && !inv1 ##1 sel1 == `RDM_CODE_CRC && !inv1 |=> !pin_o[1])
    else $error("crc flag not cleared on receive start");

  hard_bits_a: assert property (
    sel0 == `RDM_CODE_HARD1 && sel1 == `RDM_CODE_HARD0 && !inv0 && !inv1
    |=> pin_o[1:0] == {$past(status_i.receive_hard_bits[0]),
                       $past(status_i.receive_hard_bits[1])})
    else $error("hard bits on wrong pins");

  tick_route_a: assert property (
    sel2 == `RDM_CODE_TICK && !inv2
    |=> pin_o[2] == $past(status_i.symbol_tick))
    else $error("symbol tick not on pin 1.7");

  amp_ctrl_a: assert property (
    sel0 == `RDM_CODE_PAPD && sel2 == `RDM_CODE_LNAPD && !inv0 && !inv2
    |=> pin_o[0] == $past(status_i.power_amp_powerdown)
        && pin_o[2] == $past(status_i.low_noise_amp_powerdown))
    else $error("amplifier controls misrouted");

  const_level_a: assert property (
    sel1 == `RDM_CODE_ZERO [*2]
    |-> pin_o[1] == $past(inv1) && !pin_oe_n_o[1])
    else $error("constant level wrong on pin 1.6");

  reserved_port_a: assert property (
    sel2 == `RDM_CODE_RSVD
    |=> !ovr[2] && pin_oe_n_o[2] == ($past(port_i[2].function_select)
        ? !$past(port_i[2].periph_oe) : !$past(port_i[2].gpio_dir)))
    else $error("reserved code did not fall back to port");

  hi_write_a: assert property (
    wr_i && addr_i == `RDM_ADDR_CFG_HI
    |=> cfg[2] == ($past(wdata_i) & `RDM_CFG_MASK))
    else $error("selector for pin 1.7 not written");

  mid_write_a: assert property (
    wr_i && addr_i == `RDM_ADDR_CFG_MID
    |=> cfg[1] == ($past(wdata_i) & `RDM_CFG_MASK))
    else $error("selector for pin 1.6 not written");

  lo_write_a: assert property (
    wr_i && addr_i == `RDM_ADDR_CFG_LO
    |=> cfg[0] == ($past(wdata_i) & `RDM_CFG_MASK))
    else $error("selector for pin 1.5 not written");

  status_no_write_a: assert property (
    wr_i && addr_i == `RDM_ADDR_STATUS
    |=> $stable(cfg[0]) && $stable(cfg[1]) && $stable(cfg[2]))
    else $error("write to status changed a selector");

  cfg_mask_a: assert property (
    cfg[0] == (cfg[0] & `RDM_CFG_MASK) && cfg[1] == (cfg[1] & `RDM_CFG_MASK)
    && cfg[2] == (cfg[2] & `RDM_CFG_MASK))
    else $error("selector holds bits outside its fields");

  status_read_a: assert property (
    rd_i && addr_i == `RDM_ADDR_STATUS
    |=> rdata_o == {1'b0, $past(crc_ok), $past(pin_o), $past(ovr)})
    else $error("status register read wrong");

  unmapped_read_a: assert property (
    rd_i && addr_i != `RDM_ADDR_CFG_HI && addr_i != `RDM_ADDR_CFG_MID
    && addr_i != `RDM_ADDR_CFG_LO && addr_i != `RDM_ADDR_STATUS
    |=> rdata_o == `RDM_RDATA_IDLE)
    else $error("unmapped read not idle");

  crc_set_a: assert property (
    crc_check_i && crc_match_i |=> crc_ok)
    else $error("crc flag not set by a match");

  crc_drop_a: assert property (
    (rx_start_i || crc_check_i) && !(crc_check_i && crc_match_i)
    |=> !crc_ok)
    else $error("crc flag not cleared");

  crc_hold_a: assert property (
    !crc_check_i && !rx_start_i |=> $stable(crc_ok))
    else $error("crc flag changed without an event");

  override_drive_a: assert property (
    (ovr & pin_oe_n_o) == '0)
    else $error("overridden pin not driving");

  periph_mode_a: assert property (
    sel1 == `RDM_CODE_PORT && port_i[1].function_select
    |=> pin_o[1] == $past(port_i[1].periph_out)
        && pin_oe_n_o[1] == !$past(port_i[1].periph_oe) && !ovr[1])
    else $error("pin 1.6 did not follow peripheral");

  tick_capture_c: cover property (
    sel2 == `RDM_CODE_TICK && sel0 == `RDM_CODE_HARD0
    && status_i.symbol_tick);

  crc_seen_c: cover property (
    sel1 == `RDM_CODE_CRC ##1 pin_o[1] ##[1:20] rx_start_i);

  const_one_c: cover property (
    sel0 == `RDM_CODE_ZERO && inv0 ##1 pin_o[0]);

  status_read_c: cover property (
    rd_i && addr_i == `RDM_ADDR_STATUS ##1 rdata_o != `RDM_RDATA_IDLE);

endmodule : rdm_top

// ===== rdm_probe.sv
`timescale 1ns/1ns
module rdm_probe (
  // clock
  input wire logic clock_i,
  // pins seen from outside
  input wire logic [2:0] pin_i,
  input wire logic [2:0] pin_oe_n_i,
  // resolved wire levels
  output logic [2:0] wire_o
);
  // ----------------------------------------
  // undriven pins float, shown as a toggling pattern
  // ----------------------------------------
  logic [2:0] float_q = 3'b000;

  always @(posedge clock_i) begin
    float_q <= ~float_q;
  end

  // driven pins win over the floating level
  assign wire_o = (pin_i & ~pin_oe_n_i) | (float_q & pin_oe_n_i);
endmodule : rdm_probe

// ===== rdm_top_tb.sv
`timescale 1ns/1ns
`include "rdm_cfg.svh"
module rdm_top_tb;
  typedef struct {logic [7:0] exp; int due; bit pin;} rdm_note_t;
  // ----------------------------------------
  // signals and model state
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  rdm_pkg::rdm_radio_status_t status_i = '0;
  logic crc_check_i = 1'b0;
  logic crc_match_i = 1'b0;
  logic rx_start_i = 1'b0;
  rdm_pkg::rdm_port_pin_t [2:0] port_i = '0;
  logic [2:0] pin_o;
  logic [2:0] pin_oe_n_o;
  logic [2:0] pin_wire;
  rdm_note_t notes[$];
  rdm_note_t nt;
  logic [7:0] act;
  logic [7:0] cfg_m [3] = '{8'h00, 8'h00, 8'h00};
  rdm_pkg::rdm_radio_status_t st_m = '0;
  rdm_pkg::rdm_port_pin_t [2:0] port_m = '0;
  logic crc_m = 1'b0;
  logic [7:0] cv;
  logic [2:0] ev;
  logic [5:0] codes [12] = '{6'h08, 6'h09, 6'h0E, 6'h0F, 6'h16, 6'h17,
    6'h1B, 6'h1C, 6'h1D, 6'h2F, 6'h00, 6'h1E};
  logic [2:0] evs [8] = '{3'h6, 3'h0, 3'h1, 3'h6, 3'h4, 3'h7, 3'h5, 3'h6};
  int cyc = 0;
  int miscompares = 0;
  int tests_run = 0;
  int p;

  always #4 clock_i = ~clock_i;

  rdm_top #(.NUM_PINS(3)) i_dut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .status_i(status_i), .crc_check_i(crc_check_i),
    .crc_match_i(crc_match_i), .rx_start_i(rx_start_i), .port_i(port_i),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o)
  );

  rdm_probe i_probe (
    .clock_i(clock_i), .pin_i(pin_o), .pin_oe_n_i(pin_oe_n_o),
    .wire_o(pin_wire)
  );

  // ----------------------------------------
  // expected pin levels
  // ----------------------------------------
  function automatic logic [1:0] one_pin(input logic [7:0] c,
                                         input rdm_pkg::rdm_port_pin_t pt);
    logic s;
    case (c[5:0])
      6'h08: s = st_m.preamble_reached;
      6'h09: s = st_m.clear_channel;
      6'h0E: s = st_m.carrier_sense;
      6'h0F: s = crc_m;
      6'h16: s = st_m.receive_hard_bits[1];
      6'h17: s = st_m.receive_hard_bits[0];
      6'h1B: s = st_m.power_amp_powerdown;
      6'h1C: s = st_m.low_noise_amp_powerdown;
      6'h1D: s = st_m.symbol_tick;
      6'h2F: s = 1'b0;
      default: return pt.function_select ? {~pt.periph_oe, pt.periph_out}
                                         : {~pt.gpio_dir, pt.gpio_out};
    endcase
    return {1'b0, s ^ c[6]};
  endfunction : one_pin

  function automatic logic [7:0] pins_exp();
    logic [2:0] v;
    logic [2:0] oe;
    for (int k = 0; k < 3; k++) begin
      {oe[k], v[k]} = one_pin(cfg_m[k], port_m[k]);
    end
    return {2'b00, oe, v};
  endfunction : pins_exp

  function automatic logic [15:0] cfg_addr(input int k);
    return `RDM_ADDR_CFG_LO - 16'(k);
  endfunction : cfg_addr

  // ----------------------------------------
  // bus tasks and notes
  // ----------------------------------------
  task automatic note(input logic [7:0] e, input int lat, input bit pn);
    notes.push_back('{e, cyc + lat, pn});
  endtask : note

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    rd_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr_i <= a;
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    note(e, 2, 1'b0);
  endtask : rd

  task automatic idle();
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
  endtask : idle

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // monitor and timeout
  // ----------------------------------------
  always @(negedge clock_i) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      nt = notes.pop_front();
      act = nt.pin ? {1'b0, |(~pin_oe_n_o & (pin_wire ^ pin_o)),
                      pin_oe_n_o, pin_o} : rdata_o;
      tests_run++;
      if (act !== nt.exp) begin
        miscompares++;
        $display("mismatch at %0t: expected %0h got %0h", $time, nt.exp, act);
      end
    end
  end

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h58C02C02));
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    note(pins_exp(), 2, 1'b1);
    for (int k = 0; k < 3; k++) begin
      rd(cfg_addr(k), 8'h00);
    end
    wr(`RDM_ADDR_STATUS, 8'hFF);
    wr(16'hDF2E, 8'h55);
    rd(16'hDF33, 8'h00);
    rd(`RDM_ADDR_CFG_HI, 8'h00);
    for (int i = 0; i < 36; i++) begin
      p = (i / 12 + i) % 3;
      cv = {2'($urandom), codes[i % 12]};
      wr(cfg_addr(p), cv);
      st_m = rdm_pkg::rdm_radio_status_t'(8'($urandom));
      port_m = 15'($urandom);
      status_i <= st_m;
      port_i <= port_m;
      cfg_m[p] = cv & 8'h7F;
      note(pins_exp(), 3, 1'b1);
      rd(cfg_addr(p), cfg_m[p]);
    end
    wr(`RDM_ADDR_CFG_HI, 8'h4F);
    wr(`RDM_ADDR_CFG_MID, 8'h0F);
    wr(`RDM_ADDR_CFG_LO, 8'h00);
    cfg_m = '{8'h00, 8'h0F, 8'h4F};
    idle();
    for (int k = 0; k < 8; k++) begin
      ev = evs[k];
      @(posedge clock_i);
      crc_check_i <= ev[2];
      crc_match_i <= ev[1];
      rx_start_i <= ev[0];
      crc_m = (ev[2] && ev[1]) ? 1'b1 : ((ev[2] || ev[0]) ? 1'b0 : crc_m);
      note(pins_exp(), 3, 1'b1);
    end
    @(posedge clock_i);
    crc_check_i <= 1'b0;
    rx_start_i <= 1'b0;
    cv = pins_exp();
    rd(`RDM_ADDR_STATUS, {1'b0, crc_m, cv[2:0], 3'b110});
    idle();
    repeat (5) @(posedge clock_i);
    results();
  end
endmodule : rdm_top_tb
